// *** bench/proc_chain_model.sv ***
// stand-in for the digital processing chain between proc and ret
`timescale 1ns/100ps
`default_nettype none
module proc_chain_model #(
    parameter logic [11:0] LUT_XOR = 12'h0a5  // lookup stand-in, leaves bits 11:8
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // stream from generator
    input  wire logic        in_valid,
    input  wire logic        in_sof,
    input  wire logic        in_eol,
    input  wire logic [11:0] in_data,
    // stream back to generator
    output logic             out_valid,
    output logic             out_sof,
    output logic             out_eol,
    output logic      [11:0] out_data
);
    // -------------------------------------------------------------
    // one-cycle chain; idle data toggles so stale pixels never match
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {out_valid, out_sof, out_eol, out_data} <= '0;
        end else begin
            out_valid <= in_valid;
            out_sof   <= in_valid & in_sof;
            out_eol   <= in_valid & in_eol;
            out_data  <= in_valid ? (in_data ^ LUT_XOR) : ~out_data;
        end
    end
endmodule // proc_chain_model
`default_nettype wire

// *** bench/test_pattern_generator_tb_top.sv ***
// self-checking bench for the test pattern generator
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("Error %s expected %h seen %h", n, b, a); end end
module test_pattern_generator_tb_top
    import test_pattern_pkg::*;
;
    // -------------------------------------------------------------
    // signals, design and chain model
    // -------------------------------------------------------------
    localparam logic [11:0] LUTX = 12'h0a5;  // must match the chain model
    logic sys_clk = 0, reset_n = 0, acq_start = 0, sen_valid = 0, sen_sof = 0, sen_eol = 0;
    logic [2:0]       pattern_select = 3'h0;
    logic [PIX_W-1:0] sen_data = '0, proc_data, ret_data, tx_data;
    logic             proc_valid, proc_sof, proc_eol, ret_valid, ret_sof, ret_eol;
    logic             tx_valid, tx_sof, tx_eol, tg_active;
    logic [1:0]       tx_fmt;
    logic [15:0]      exp_q[$];              // {eol, sof, fmt, data} per pixel
    logic [15:0]      e;
    int               err_total, cmp_count, fc, seed = 32'h9776;
    test_pattern_generator #(.IS_COLOUR(1'b1)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .pattern_select(pattern_select), .acq_start(acq_start), .sen_valid(sen_valid),
        .sen_sof(sen_sof), .sen_eol(sen_eol), .sen_data(sen_data), .proc_valid(proc_valid),
        .proc_sof(proc_sof), .proc_eol(proc_eol), .proc_data(proc_data),
        .ret_valid(ret_valid), .ret_sof(ret_sof), .ret_eol(ret_eol), .ret_data(ret_data),
        .tx_valid(tx_valid), .tx_sof(tx_sof), .tx_eol(tx_eol), .tx_data(tx_data),
        .tx_fmt(tx_fmt), .tg_active(tg_active));
    proc_chain_model #(.LUT_XOR(LUTX)) pc (.sys_clk(sys_clk), .reset_n(reset_n),
        .in_valid(proc_valid), .in_sof(proc_sof), .in_eol(proc_eol), .in_data(proc_data),
        .out_valid(ret_valid), .out_sof(ret_sof), .out_eol(ret_eol), .out_data(ret_data));
    initial forever #2 sys_clk = ~sys_clk;
    // -------------------------------------------------------------
    // one frame: acquisition pulse, then rows of pixels with gaps
    // -------------------------------------------------------------
    task automatic frame(input logic [2:0] p, input int rows, input int cols);
        logic [11:0] v, x, s;
        logic [1:0]  f;
        @(negedge sys_clk);
        pattern_select = p;
        acq_start = 1'b1;
        fc++;
        @(negedge sys_clk);
        acq_start = 1'b0;
        for (int r = 0; r < rows; r++) begin
            for (int c = 0; c < cols; c++) begin
                while (($random(seed) & 3) == 0) begin
                    sen_valid = 1'b0;
                    sen_data = $random(seed);  // sensor noise must stay hidden
                    @(negedge sys_clk);
                end
                s = $random(seed);
                v = 12'(c + r + fc);
                case (p)
                    3'h1: x = {4'h0, 8'(c + r)};
                    3'h2, 3'h6: x = {4'h0, v[7:0]};
                    3'h4: x = {4'h0, v[7:0]} ^ LUTX;
                    3'h3: x = v;
                    3'h5: x = v ^ LUTX;
                    default: x = s ^ LUTX;  // live image through the chain
                endcase
                f = (p inside {1, 2, 4}) ? 2'h1 : (p inside {3, 5}) ? 2'h2 : (p == 6) ? 2'h3 : 2'h0;
                exp_q.push_back({c == cols - 1, r == 0 && c == 0, f, x});
                {sen_valid, sen_sof, sen_eol, sen_data} = {1'b1, r == 0 && c == 0, c == cols - 1, s};
                @(negedge sys_clk);
            end
        end
        {sen_valid, sen_sof, sen_eol} = 3'b000;
        repeat (6) @(negedge sys_clk);  // let both paths drain before a switch
    endtask
    // -------------------------------------------------------------
    // verdict, output watcher, watchdog, main sequence
    // -------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // outputs are looked at mid-cycle, where they have settled
    always @(negedge sys_clk) begin
        if (reset_n && tx_valid === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK("tx_eol", tx_eol, e[15])
            `CHK("tx_sof", tx_sof, e[14])
            `CHK("tx_fmt", tx_fmt, e[13:12])
            `CHK("tg_active", tg_active, e[13:12] != 2'h0)
            `CHK("tx_data", tx_data, e[11:0])
        end
    end
    initial begin
        #80000;
        err_total++;
        results();
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 10; i++)
            frame(3'(i % 8), 3, 5);
        frame(3'h2, 2, 260);  // column wrap past 255
        frame(3'h5, 2, 260);
        `CHK("pending", exp_q.size(), 0)
        results();
    end
endmodule // test_pattern_generator_tb_top
`default_nettype wire

// *** bench/test_pattern_monitor.sv ***
// port assertions for the test pattern generator
`timescale 1ns/100ps
`default_nettype none
module test_pattern_monitor
    import test_pattern_pkg::*;
(
    // clock, reset, control
    input wire logic             sys_clk,
    input wire logic             reset_n,
    input wire logic [2:0]       pattern_select,
    // sensor side
    input wire logic             sen_valid,
    input wire logic             sen_sof,
    // return side
    input wire logic             ret_valid,
    input wire logic [PIX_W-1:0] ret_data,
    // outputs watched
    input wire logic             proc_valid,
    input wire logic [PIX_W-1:0] proc_data,
    input wire logic             tx_valid,
    input wire logic             tx_sof,
    input wire logic [PIX_W-1:0] tx_data,
    input wire logic [1:0]       tx_fmt,
    input wire logic             tg_active
);
    // -------------------------------------------------------------
    // properties, one clock domain
    // -------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_off_path: assert property (ret_valid && pattern_select == 3'h0 |=>
        tx_valid && tx_data == $past(ret_data)) else $error("live path lost");
    a_first_sof: assert property (sen_valid && sen_sof && pattern_select == 3'h1 |->
        ##2 tx_sof && tx_data == 12'h000) else $error("first pixel not zero");
    a_proc_narrow: assert property (sen_valid && pattern_select == 3'h4 |=>
        proc_valid && proc_data[11:8] == 4'h0) else $error("pattern 4 not 8 bit");
    a_bypass_lag: assert property (sen_valid && pattern_select == 3'h3 |->
        ##2 tx_valid) else $error("bypass latency");
    a_bypass_ret: assert property ((pattern_select == 3'h3) [*3] ##0
        !$past(sen_valid, 2) |-> !tx_valid) else $error("bypass used return");
    a_active_on: assert property (pattern_select inside {[3'h1:3'h5]} |=>
        tg_active) else $error("generator idle");
    a_active_off: assert property (pattern_select == 3'h0 |=> !tg_active)
        else $error("generator busy");
    a_bayer_fmt: assert property ((pattern_select == 3'h6) [*2] |=>
        tx_fmt == 2'h3) else $error("colour format");
    c_proc: cover property (pattern_select == 3'h5 && tx_valid);
    c_colour: cover property (pattern_select == 3'h6 && tx_valid);
    c_sof: cover property (pattern_select == 3'h2 && tx_sof);
endmodule // test_pattern_monitor
bind test_pattern_generator test_pattern_monitor mon (
    .sys_clk        (sys_clk),
    .reset_n        (reset_n),
    .pattern_select (pattern_select),
    .sen_valid      (sen_valid),
    .sen_sof        (sen_sof),
    .ret_valid      (ret_valid),
    .ret_data       (ret_data),
    .proc_valid     (proc_valid),
    .proc_data      (proc_data),
    .tx_valid       (tx_valid),
    .tx_sof         (tx_sof),
    .tx_data        (tx_data),
    .tx_fmt         (tx_fmt),
    .tg_active      (tg_active)
);
`default_nettype wire

// *** design/pattern_adder.sv ***
// diagonal gradient value: column plus row plus offset, wrapped to width
`timescale 1ns/100ps
`default_nettype none
module pattern_adder #(
    parameter int IDX_W = 16,
    parameter int OUT_W = 12
) (
    // operands
    input  wire logic [IDX_W-1:0] col_idx,
    input  wire logic [IDX_W-1:0] row_idx,
    input  wire logic [OUT_W-1:0] offset,
    // result
    output logic      [OUT_W-1:0] value
);
    // elaboration check: the low slices below would not exist otherwise
    if (OUT_W > IDX_W) begin : g_bad
        $error("OUT_W must not exceed IDX_W");
    end

    // low bits only: the modulo is a plain truncation
    assign value = col_idx[OUT_W-1:0] + row_idx[OUT_W-1:0] + offset;
endmodule // pattern_adder
`default_nettype wire

// *** design/test_pattern_generator.sv ***
// test pattern generator sitting in the pixel stream of an area-scan camera
`timescale 1ns/100ps
`default_nettype none
module test_pattern_generator
    import test_pattern_pkg::*;
#(
    parameter int IDX_W     = 16,   // width of row and column counters
    parameter bit IS_COLOUR = 1'b0  // colour variant of the device
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // control
    input  wire logic [2:0]       pattern_select,
    input  wire logic             acq_start,      // one-cycle pulse, new acquisition
    // sensor pixel stream in
    input  wire logic             sen_valid,
    input  wire logic             sen_sof,        // first pixel of frame
    input  wire logic             sen_eol,        // last pixel of a line
    input  wire logic [PIX_W-1:0] sen_data,
    // stream towards digital processing
    output logic                  proc_valid,
    output logic                  proc_sof,
    output logic                  proc_eol,
    output logic      [PIX_W-1:0] proc_data,
    // stream returning from digital processing
    input  wire logic             ret_valid,
    input  wire logic             ret_sof,
    input  wire logic             ret_eol,
    input  wire logic [PIX_W-1:0] ret_data,
    // stream to transmission
    output logic                  tx_valid,
    output logic                  tx_sof,
    output logic                  tx_eol,
    output logic      [PIX_W-1:0] tx_data,
    output logic      [1:0]       tx_fmt,
    output logic                  tg_active       // generator in use
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (IDX_W < PIX_W) begin : g_bad
        $error("IDX_W must be at least PIX_W");
    end

    // ------------------------------------------------------------
    // selection decode
    // ------------------------------------------------------------
    pattern_sel_t sel;        // validated selection
    logic         gen_on;     // a pattern is running
    logic         bypass;     // pattern skips processing
    logic         wide;       // 12-bit pattern

    // unknown codes and colour on mono parts fall back to live image
    always_comb begin
        sel = pattern_select_disabled;
        unique case (pattern_select)
            3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
                sel = pattern_sel_t'(pattern_select);
            3'h6: begin
                if (IS_COLOUR) begin
                    sel = pattern_select_colour;
                end
            end
            default: sel = pattern_select_disabled;
        endcase
    end
    assign gen_on = (sel != pattern_select_disabled);
    assign bypass = (sel == pattern_select_first) || (sel == pattern_select_moving8)
                  || (sel == pattern_select_moving12)
                  || (sel == pattern_select_colour);
    assign wide   = (sel == pattern_select_moving12) || (sel == pattern_select_proc12);

    // ------------------------------------------------------------
    // frame counter
    // ------------------------------------------------------------
    logic [FRAME_CNT_W-1:0] frame_cnt_q;  // shifts the moving patterns

    // one step per acquisition moves the image one pixel left
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_cnt_q <= FRAME_CNT_RST;
        end else if (acq_start) begin
            frame_cnt_q <= frame_cnt_q + FRAME_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // row and column position
    // ------------------------------------------------------------
    logic [IDX_W-1:0] col_q;  // column of the current pixel
    logic [IDX_W-1:0] row_q;  // row of the current pixel
    logic [IDX_W-1:0] col;    // column seen by the adder
    logic [IDX_W-1:0] row;    // row seen by the adder

    // start of frame forces the origin so a lost eol cannot drift it
    assign col = sen_sof ? '0 : col_q;
    assign row = sen_sof ? '0 : row_q;

    // indices walk the scan order, timed by the sensor's framing
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            col_q <= '0;
            row_q <= '0;
        end else if (sen_valid) begin
            if (sen_eol) begin
                col_q <= '0;
                row_q <= row + IDX_W'(1);
            end else begin
                col_q <= col + IDX_W'(1);
                row_q <= row;
            end
        end
    end

    // ------------------------------------------------------------
    // gradient value
    // ------------------------------------------------------------
    logic [PIX_W-1:0] offset;  // frame term, zero for the fixed pattern
    logic [PIX_W-1:0] grad;    // 12-bit diagonal sum
    logic [PIX_W-1:0] pix;     // value after width selection

    assign offset = (sel == pattern_select_first) ? PIX_RST : frame_cnt_q;

    pattern_adder #(
        .IDX_W (IDX_W),
        .OUT_W (PIX_W)
    ) u_adder (
        .col_idx (col),
        .row_idx (row),
        .offset  (offset),
        .value   (grad)
    );

    // 8-bit patterns keep only the low byte, i.e. mod 256; sensor data unused
    assign pix = wide ? grad
               : {4'h0, grad[MASK8_W-1:0]};

    // ------------------------------------------------------------
    // feed into digital processing
    // ------------------------------------------------------------
    // processed patterns replace sensor data ahead of the lut stage;
    // the analog path never enters, so gain and exposure have no hold
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            proc_valid <= 1'b0;
            proc_sof   <= 1'b0;
            proc_eol   <= 1'b0;
            proc_data  <= PIX_RST;
        end else begin
            proc_valid <= sen_valid;
            proc_sof   <= sen_sof;
            proc_eol   <= sen_eol;
            if (gen_on && !bypass) begin
                proc_data <= pix;
            end else begin
                proc_data <= sen_data;
            end
        end
    end

    // ------------------------------------------------------------
    // bypass stage, matched in latency to one register
    // ------------------------------------------------------------
    logic             byp_valid_q;  // held pattern pixel
    logic             byp_sof_q;
    logic             byp_eol_q;
    logic [PIX_W-1:0] byp_data_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            byp_valid_q <= 1'b0;
            byp_sof_q   <= 1'b0;
            byp_eol_q   <= 1'b0;
            byp_data_q  <= PIX_RST;
        end else begin
            byp_valid_q <= sen_valid;
            byp_sof_q   <= sen_sof;
            byp_eol_q   <= sen_eol;
            byp_data_q  <= pix;
        end
    end

    // ------------------------------------------------------------
    // output to transmission
    // ------------------------------------------------------------
    // bypass patterns skip the lut path entirely; others take the return
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_valid  <= 1'b0;
            tx_sof    <= 1'b0;
            tx_eol    <= 1'b0;
            tx_data   <= PIX_RST;
            tx_fmt    <= fmt_passthru;
            tg_active <= 1'b0;
        end else begin
            tg_active <= gen_on;
            if (gen_on && bypass) begin
                tx_valid <= byp_valid_q;
                tx_sof   <= byp_sof_q;
                tx_eol   <= byp_eol_q;
                tx_data  <= byp_data_q;
            end else begin
                tx_valid <= ret_valid;
                tx_sof   <= ret_sof;
                tx_eol   <= ret_eol;
                tx_data  <= ret_data;
            end
            if (sel == pattern_select_colour) begin
                tx_fmt <= fmt_bayer_gb8;
            end else if (!gen_on) begin
                tx_fmt <= fmt_passthru;
            end else if (wide) begin
                tx_fmt <= fmt_mono12;
            end else begin
                tx_fmt <= fmt_mono8;
            end
        end
    end

endmodule // test_pattern_generator
`default_nettype wire

// *** shared/test_pattern_pkg.sv ***
// constants and types for the internal test pattern generator
`default_nettype none
package test_pattern_pkg;

    // pattern selection codes
    typedef enum logic [2:0] {
        pattern_select_disabled = 3'h0,
        pattern_select_first    = 3'h1,
        pattern_select_moving8  = 3'h2,
        pattern_select_moving12 = 3'h3,
        pattern_select_proc8    = 3'h4,
        pattern_select_proc12   = 3'h5,
        pattern_select_colour   = 3'h6
    } pattern_sel_t;

    // output pixel formats
    typedef enum logic [1:0] {
        fmt_passthru = 2'h0,
        fmt_mono8    = 2'h1,
        fmt_mono12   = 2'h2,
        fmt_bayer_gb8 = 2'h3
    } pixel_fmt_t;

    // pixel and counter widths
    localparam int PIX_W      = 12;
    localparam int MASK8_W    = 8;
    localparam int FRAME_CNT_W = 12;

    // reset values
    localparam logic [FRAME_CNT_W-1:0] FRAME_CNT_RST = 12'h000;
    localparam logic [PIX_W-1:0]       PIX_RST       = 12'h000;

endpackage
`default_nettype wire
